/* testbench/angle_sensor_spi_slave_test.sv */
module angle_sensor_spi_slave_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst;
  logic factory_load;
  logic [15:0] angle_raw;
  logic field_high_flag;
  logic field_low_flag;
  logic rotation_ccw;
  logic [15:0] zero_setting;
  logic [7:0] threshold_cfg;
  logic memory_write_wait;
  logic mode3;
  logic start;
  logic [15:0] tx_frame;
  logic [4:0] num_bits;
  logic busy;
  logic done;
  logic [15:0] rx_frame;
  logic [15:0] rx;
  int miscompares;
  int comparisons;
  int cycles;

  asp_spi_if i_asp_spi_if ();

  // Refresh at its default of 40 cycles and a short memory wait keep the run brief; 12-bit angle exercises padding
  asp_sensor_end #(.ANGLE_BITS(12), .REFRESH_CYCLES(40), .WAIT_CYCLES(50)) i_asp_sensor_end (
    .mclk(mclk), .rst(rst), .factory_load(factory_load), .angle_raw(angle_raw),
    .field_high_flag(field_high_flag), .field_low_flag(field_low_flag),
    .rotation_ccw(rotation_ccw), .zero_setting(zero_setting), .threshold_cfg(threshold_cfg),
    .memory_write_wait(memory_write_wait), .link(i_asp_spi_if.dev));

  asp_master_end #(.WAIT_CYCLES(50)) i_asp_master_end (
    .mclk(mclk), .rst(rst), .mode3(mode3), .start(start), .tx_frame(tx_frame),
    .num_bits(num_bits), .busy(busy), .done(done), .rx_frame(rx_frame),
    .link(i_asp_spi_if.host));

  asp_link_props i_asp_link_props (
    .mclk(mclk), .rst(rst), .cs_n(i_asp_spi_if.cs_n), .sclk(i_asp_spi_if.sclk),
    .mosi(i_asp_spi_if.mosi), .miso_drv(i_asp_spi_if.miso_drv),
    .miso_oe(i_asp_spi_if.miso_oe), .miso(i_asp_spi_if.miso));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_flag(input string name, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  // One frame; poke swaps the raw angle while chip select is low
  task automatic xfer(input logic [15:0] tx, input logic [4:0] nb, input logic poke);
    int n;
    @(negedge mclk);
    start = 1'b1;
    tx_frame = tx;
    num_bits = nb;
    @(negedge mclk);
    start = 1'b0;
    for (n = 0; n < 400 && done !== 1'b1; n++)
    begin
      if (n == 30 && poke)
        angle_raw = ~angle_raw;
      @(negedge mclk);
    end
    check_flag("done", 1'b1, done);
    rx = rx_frame;
    for (n = 0; n < 200 && busy !== 1'b0; n++)
      @(negedge mclk);
  endtask

  task automatic rd_angle(input logic m3, input logic [4:0] nb, input logic [15:0] e,
                          input logic poke);
    mode3 = m3;
    repeat (2) @(negedge mclk);
    xfer(16'h0000, nb, poke);
    if (nb == 5'h08)
      check_word("angle short", {8'h00, e[15:8]}, {8'h00, rx[7:0]});
    else
      check_word("angle", e, rx);
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
    xfer({3'h2, a, 8'h00}, 5'h10, 1'b0);
    xfer(16'h0000, 5'h10, 1'b0);
    check_word("register", {e, 8'h00}, rx);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scn_angle();
    angle_raw = 16'hA5C3;
    repeat (100) @(negedge mclk);
    rd_angle(1'b0, 5'h10, 16'hA5C0, 1'b0);
    rd_angle(1'b0, 5'h10, 16'hA5C0, 1'b0);
    rd_angle(1'b1, 5'h10, 16'hA5C0, 1'b0);
    rd_angle(1'b0, 5'h08, 16'hA5C0, 1'b0);
  endtask

  task automatic scn_freeze();
    angle_raw = 16'h3C5A;
    repeat (100) @(negedge mclk);
    rd_angle(1'b1, 5'h10, 16'h3C50, 1'b1);
    repeat (100) @(negedge mclk);
    rd_angle(1'b0, 5'h10, 16'hC3A0, 1'b0);
  endtask

  task automatic scn_direction();
    xfer({3'h4, 5'h09, 8'h80}, 5'h10, 1'b0);
    check_flag("write wait", 1'b1, memory_write_wait);
    xfer(16'h0000, 5'h10, 1'b0);
    check_word("echo", 16'h8000, rx);
    check_flag("write wait over", 1'b0, memory_write_wait);
    check_flag("ccw", 1'b1, rotation_ccw);
    // Ticks are missed while frozen; let one land after the direction change
    repeat (100) @(negedge mclk);
    rd_angle(1'b0, 5'h10, 16'h3C50, 1'b0);
  endtask

  task automatic scn_flags();
    field_high_flag = 1'b1;
    field_low_flag = 1'b0;
    repeat (5) @(negedge mclk);
    rd_reg(5'h1B, 8'h80);
    field_high_flag = 1'b0;
    field_low_flag = 1'b1;
    repeat (5) @(negedge mclk);
    rd_reg(5'h1B, 8'h40);
  endtask

  task automatic scn_short_cmd();
    xfer({3'h4, 5'h06, 8'h55}, 5'h0A, 1'b0);
    rd_reg(5'h06, 8'h1C);
    check_word("threshold", 16'h001C, {8'h00, threshold_cfg});
    check_word("zero", 16'h0000, zero_setting);
  endtask

  // Configuration must come back from the store after a fresh reset
  task automatic scn_reload();
    rst = 1'b1;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    check_flag("ccw reload", 1'b1, rotation_ccw);
    rd_reg(5'h09, 8'h80);
  endtask

  initial
  begin
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    rst = 1'b1;
    factory_load = 1'b1;
    angle_raw = 16'h0000;
    field_high_flag = 1'b0;
    field_low_flag = 1'b0;
    mode3 = 1'b0;
    start = 1'b0;
    tx_frame = 16'h0000;
    num_bits = 5'h10;
    repeat (19) @(negedge mclk);
    factory_load = 1'b0;
    @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    scn_angle();
    scn_freeze();
    scn_direction();
    scn_flags();
    scn_short_cmd();
    scn_reload();
    conclude();
  end
endmodule

/* testbench/asp_link_props.sv */
module asp_link_props (
  input logic mclk,
  input logic rst,
  input logic cs_n,
  input logic sclk,
  input logic mosi,
  input logic miso_drv,
  input logic miso_oe,
  input logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sclk_q;
  logic [4:0] rise_cnt_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  always_ff @(posedge mclk)
  begin
    sclk_q <= sclk;
  end

  // Rising serial clock edges in the current frame; held one cycle past chip select rise
  always_ff @(posedge mclk)
  begin
    if (rst || cs_n)
      rise_cnt_q <= 5'h00;
    else if (sclk && !sclk_q)
      rise_cnt_q <= rise_cnt_q + 5'h01;
  end

  property p_idle_release;
    cs_n |-> !miso_oe && !miso;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("miso busy while idle");

  property p_drive_selected;
    !cs_n |-> miso_oe && (miso == miso_drv);
  endproperty
  a_drive_selected: assert property (p_drive_selected) else $error("miso not driven");

  property p_mosi_hold;
    !cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");

  property p_mosi_on_fall;
    !cs_n && !$past(cs_n) && $changed(mosi) |-> !sclk;
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("mosi moved off falling");

  // Skip the first cycles of a frame: the reply word is still being frozen then
  property p_miso_hold;
    !cs_n && !$past(cs_n, 4) && sclk && $past(sclk) |-> $stable(miso_drv);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sclk high");

  property p_miso_on_fall;
    !cs_n && !$past(cs_n, 4) && $changed(miso_drv) |-> !sclk;
  endproperty
  a_miso_on_fall: assert property (p_miso_on_fall) else $error("miso moved off falling");

  property p_frame_len;
    rise_cnt_q <= 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame over sixteen clocks");

  property p_idle_gap;
    $rose(cs_n) |-> cs_n [*6];
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("chip select idle too short");

  c_mode3_start: cover property ($fell(cs_n) && sclk);
  c_mode0_start: cover property ($fell(cs_n) && !sclk);
  c_full_frame: cover property ($rose(cs_n) && rise_cnt_q == 5'h10);
  c_short_frame: cover property ($rose(cs_n) && rise_cnt_q == 5'h08);
endmodule

/* verilog/asp_master_end.sv */
module asp_master_end #(
  parameter int HALF_CYCLES = asp_pkg::HOST_HALF_CYCLES,
  parameter int WAIT_CYCLES = asp_pkg::MEMORY_WRITE_WAIT_CYCLES
) (
  input logic mclk,
  input logic rst,
  input logic mode3,
  input logic start,
  input logic [15:0] tx_frame,
  input logic [4:0] num_bits,
  output logic busy,
  output logic done,
  output logic [15:0] rx_frame,
  asp_spi_if.host link
);

  asp_pkg::asp_host_state_type state_q;
  logic [31:0] timer_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [4:0] bits_q;
  logic [4:0] sent_q;
  logic prev_reg_q;
  logic miso_s1_q;
  logic miso_s2_q;
  logic cs_n_q;
  logic sclk_q;
  logic mosi_q;
  logic done_q;
  logic timer_done;
  logic last_bit;
  logic is_read;
  logic is_write;
  logic [31:0] gap_cycles;

  // ----------------------------------------------------------------
  // Frame classification and idle time
  // ----------------------------------------------------------------
  assign timer_done = timer_q == 32'h0;
  assign last_bit = sent_q == bits_q;
  assign is_read = bits_q == asp_pkg::FRAME_FULL &&
                   tx_q[asp_pkg::CMD_MSB:asp_pkg::CMD_LSB] == asp_pkg::CMD_READ;
  assign is_write = bits_q == asp_pkg::FRAME_FULL &&
                    tx_q[asp_pkg::CMD_MSB:asp_pkg::CMD_LSB] == asp_pkg::CMD_WRITE;

  always_comb
  begin
    if (is_write)
      gap_cycles = 32'(WAIT_CYCLES);
    else if (is_read || prev_reg_q)
      gap_cycles = 32'(asp_pkg::IDLE_REG_CYCLES);
    else
      gap_cycles = 32'(asp_pkg::IDLE_ANGLE_CYCLES);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end
    else
    begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= asp_pkg::HOST_IDLE;
      timer_q <= '0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      if (!timer_done)
        timer_q <= timer_q - 32'h1;
      case (state_q)
        asp_pkg::HOST_IDLE:
        begin
          sclk_q <= mode3;
          if (start)
          begin
            state_q <= asp_pkg::HOST_SETUP;
            timer_q <= 32'(asp_pkg::CS_LEAD_CYCLES - 1);
            cs_n_q <= 1'b0;
            mosi_q <= tx_frame[asp_pkg::FRAME_BITS-1];
          end
        end
        asp_pkg::HOST_SETUP, asp_pkg::HOST_HIGH:
          if (timer_done)
          begin
            if (state_q == asp_pkg::HOST_HIGH && last_bit)
            begin
              state_q <= asp_pkg::HOST_END;
              timer_q <= 32'(asp_pkg::CS_TRAIL_CYCLES - 1);
            end
            else
            begin
              state_q <= asp_pkg::HOST_LOW;
              timer_q <= 32'(HALF_CYCLES - 1);
              sclk_q <= 1'b0;
              mosi_q <= tx_q[asp_pkg::FRAME_BITS-1];
            end
          end
        asp_pkg::HOST_LOW:
          if (timer_done)
          begin
            state_q <= asp_pkg::HOST_HIGH;
            timer_q <= 32'(HALF_CYCLES - 1);
            sclk_q <= 1'b1;
          end
        asp_pkg::HOST_END:
          if (timer_done)
          begin
            state_q <= asp_pkg::HOST_GAP;
            timer_q <= gap_cycles - 32'h1;
            cs_n_q <= 1'b1;
            sclk_q <= mode3;
            mosi_q <= 1'b0;
          end
        asp_pkg::HOST_GAP:
          if (timer_done)
            state_q <= asp_pkg::HOST_IDLE;
        default:
          state_q <= asp_pkg::HOST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data shifting
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_q <= '0;
      rx_q <= '0;
      bits_q <= asp_pkg::FRAME_FULL;
      sent_q <= '0;
      prev_reg_q <= 1'b0;
      rx_frame <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (state_q == asp_pkg::HOST_IDLE && start)
      begin
        tx_q <= tx_frame;
        bits_q <= (num_bits == '0) ? asp_pkg::FRAME_FULL : num_bits;
        sent_q <= '0;
      end
      else if (state_q == asp_pkg::HOST_LOW && timer_done)
      begin
        tx_q <= {tx_q[14:0], 1'b0};
        rx_q <= {rx_q[14:0], miso_s2_q};
        sent_q <= sent_q + asp_pkg::COUNT_ONE;
      end
      else if (state_q == asp_pkg::HOST_END && timer_done)
      begin
        rx_frame <= rx_q;
        done_q <= 1'b1;
        prev_reg_q <= is_read || is_write;
      end
    end
  end

  assign busy = state_q != asp_pkg::HOST_IDLE;
  assign done = done_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;

endmodule

/* verilog/asp_pkg.sv */
package asp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_FULL = 5'h10;
  localparam logic [4:0] COUNT_ONE = 5'h01;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 32;
  localparam logic [4:0] REG_ZERO_LO = 5'h00;
  localparam logic [4:0] REG_ZERO_HI = 5'h01;
  localparam logic [4:0] REG_THRESHOLD = 5'h06;
  localparam logic [4:0] REG_ROT_DIR = 5'h09;
  localparam logic [4:0] REG_FIELD_FLAGS = 5'h1B;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h1C;
  localparam logic [7:0] ROT_DIR_RESET = 8'h00;
  localparam int ROT_DIR_BIT = 7;
  localparam int FIELD_HIGH_BIT = 7;
  localparam int FIELD_LOW_BIT = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 40_000_000;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int REFRESH_NS = 1000;
  localparam int REFRESH_CYCLES = REFRESH_NS / MCLK_PERIOD_NS;
  localparam int MEMORY_WRITE_WAIT_MS = 20;
  localparam int MEMORY_WRITE_WAIT_CYCLES = MEMORY_WRITE_WAIT_MS * (MCLK_HZ / 1000);
  localparam int IDLE_ANGLE_NS = 150;
  localparam int IDLE_ANGLE_CYCLES = (IDLE_ANGLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int IDLE_REG_NS = 750;
  localparam int IDLE_REG_CYCLES = (IDLE_REG_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CS_LEAD_NS = 80;
  localparam int CS_LEAD_CYCLES = (CS_LEAD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CS_TRAIL_NS = 25;
  localparam int CS_TRAIL_CYCLES = (CS_TRAIL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // Half serial clock period of the master; wide enough for its MISO synchroniser
  localparam int HOST_HALF_CYCLES = 4;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_SETUP,
    HOST_LOW,
    HOST_HIGH,
    HOST_END,
    HOST_GAP
  } asp_host_state_type;

endpackage

/* verilog/asp_sensor_end.sv */
module asp_sensor_end #(
  parameter int ANGLE_BITS = 16,
  parameter int REFRESH_CYCLES = asp_pkg::REFRESH_CYCLES,
  parameter int WAIT_CYCLES = asp_pkg::MEMORY_WRITE_WAIT_CYCLES
) (
  input logic mclk,
  input logic rst,
  input logic factory_load,
  input logic [15:0] angle_raw,
  input logic field_high_flag,
  input logic field_low_flag,
  output logic rotation_ccw,
  output logic [15:0] zero_setting,
  output logic [7:0] threshold_cfg,
  output logic memory_write_wait,
  asp_spi_if.dev link
);

  localparam int RW = $clog2(REFRESH_CYCLES + 1);
  localparam int WW = $clog2(WAIT_CYCLES + 1);
  localparam logic [RW-1:0] REFRESH_LAST = RW'(REFRESH_CYCLES - 1);
  localparam logic [WW-1:0] WAIT_LOAD = WW'(WAIT_CYCLES);
  localparam logic [WW-1:0] WAIT_COMMIT = WW'(1);
  localparam logic [15:0] RES_MASK =
    16'(~((32'h1 << (asp_pkg::FRAME_BITS - ANGLE_BITS)) - 32'h1));

  // ----------------------------------------------------------------
  // Link side, clocked by the master's serial clock
  // ----------------------------------------------------------------
  // Nothing here counts time, so the clock may run arbitrarily slowly
  logic fresh_q;
  logic [4:0] rx_cnt_q;
  logic [15:0] rx_word_q;
  logic [4:0] tx_cnt_q;
  logic [15:0] out_word_q;

  // Set while chip select is high; marks the first rising edge of a frame
  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // Count survives chip select rising so the core can judge the frame
  always_ff @(posedge link.sclk or posedge rst)
  begin
    if (rst)
      rx_cnt_q <= '0;
    else if (fresh_q)
      rx_cnt_q <= asp_pkg::COUNT_ONE;
    else if (rx_cnt_q != asp_pkg::FRAME_FULL)
      rx_cnt_q <= rx_cnt_q + asp_pkg::COUNT_ONE;
  end

  always_ff @(posedge link.sclk or posedge rst)
  begin
    if (rst)
      rx_word_q <= '0;
    else if (fresh_q || rx_cnt_q != asp_pkg::FRAME_FULL)
      rx_word_q <= {rx_word_q[14:0], link.mosi};
  end

  // A falling edge before the first rising edge is the mode 3 lead-in
  // and must not advance the output bit
  always_ff @(negedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
      tx_cnt_q <= '0;
    else if (!fresh_q && tx_cnt_q != asp_pkg::FRAME_FULL)
      tx_cnt_q <= tx_cnt_q + asp_pkg::COUNT_ONE;
  end

  // Bit index 15 - n is the inverse of the low four count bits
  assign link.miso_drv = (tx_cnt_q == asp_pkg::FRAME_FULL) ? 1'b0
                         : out_word_q[~tx_cnt_q[3:0]];
  assign link.miso_oe = ~link.cs_n;

  // ----------------------------------------------------------------
  // Synchronisers into the core clock
  // ----------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic high_s1_q;
  logic high_s2_q;
  logic low_s1_q;
  logic low_s2_q;
  logic frozen;
  logic cs_rise;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      high_s1_q <= 1'b0;
      high_s2_q <= 1'b0;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
    end
    else
    begin
      high_s1_q <= field_high_flag;
      high_s2_q <= high_s1_q;
      low_s1_q <= field_low_flag;
      low_s2_q <= low_s1_q;
    end
  end

  assign frozen = ~cs_s2_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;

  // ----------------------------------------------------------------
  // Configuration store and non-volatile copy
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [asp_pkg::REG_COUNT];
  logic [7:0] nvm_q [asp_pkg::REG_COUNT];
  logic [WW-1:0] wait_cnt_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic commit;

  function automatic logic writable(input logic [4:0] a);
    return a == asp_pkg::REG_ZERO_LO || a == asp_pkg::REG_ZERO_HI ||
           a == asp_pkg::REG_THRESHOLD || a == asp_pkg::REG_ROT_DIR;
  endfunction

  assign commit = wait_cnt_q == WAIT_COMMIT;

  // Not touched by rst: contents outlive a restart
  always_ff @(posedge mclk)
  begin
    if (factory_load)
    begin
      for (int i = 0; i < asp_pkg::REG_COUNT; i++)
        nvm_q[i] <= asp_pkg::ZERO_RESET;
      nvm_q[asp_pkg::REG_THRESHOLD] <= asp_pkg::THRESHOLD_RESET;
      nvm_q[asp_pkg::REG_ROT_DIR] <= asp_pkg::ROT_DIR_RESET;
    end
    else if (commit)
      nvm_q[wr_addr_q] <= wr_data_q;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < asp_pkg::REG_COUNT; i++)
        cfg_q[i] <= nvm_q[i];
    end
    else if (commit)
      cfg_q[wr_addr_q] <= wr_data_q;
  end

  // ----------------------------------------------------------------
  // Frame decode at chip select rising
  // ----------------------------------------------------------------
  // rx_cnt_q and rx_word_q are stable from the last rising edge until the
  // next frame, which the idle time keeps well beyond the sync delay
  logic full_frame;
  logic [2:0] rx_cmd;
  logic [4:0] rx_addr;
  logic [7:0] rx_data;
  logic [7:0] rd_value;
  logic start_write;
  logic pending_q;
  logic [7:0] resp_q;

  assign full_frame = rx_cnt_q == asp_pkg::FRAME_FULL;
  assign rx_cmd = rx_word_q[asp_pkg::CMD_MSB:asp_pkg::CMD_LSB];
  assign rx_addr = rx_word_q[asp_pkg::ADDR_MSB:asp_pkg::ADDR_LSB];
  assign rx_data = rx_word_q[asp_pkg::DATA_MSB:0];

  always_comb
  begin
    rd_value = asp_pkg::PAD_BYTE;
    if (rx_addr == asp_pkg::REG_FIELD_FLAGS)
    begin
      rd_value[asp_pkg::FIELD_HIGH_BIT] = high_s2_q;
      rd_value[asp_pkg::FIELD_LOW_BIT] = low_s2_q;
    end
    else if (writable(rx_addr))
      rd_value = cfg_q[rx_addr];
  end

  // Only this link writes the store; a write during a memory update is dropped
  assign start_write = cs_rise && full_frame && rx_cmd == asp_pkg::CMD_WRITE &&
                       writable(rx_addr) && wait_cnt_q == '0;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wait_cnt_q <= '0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end
    else if (start_write)
    begin
      wait_cnt_q <= WAIT_LOAD;
      wr_addr_q <= rx_addr;
      wr_data_q <= rx_data;
    end
    else if (wait_cnt_q != '0)
      wait_cnt_q <= wait_cnt_q - WAIT_COMMIT;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pending_q <= 1'b0;
      resp_q <= '0;
    end
    else if (cs_rise)
    begin
      if (full_frame && rx_cmd == asp_pkg::CMD_READ)
      begin
        pending_q <= 1'b1;
        resp_q <= rd_value;
      end
      else if (full_frame && rx_cmd == asp_pkg::CMD_WRITE)
      begin
        pending_q <= 1'b1;
        resp_q <= start_write ? rx_data : rd_value;
      end
      else
        pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Angle sampling and output buffer
  // ----------------------------------------------------------------
  logic [RW-1:0] refresh_cnt_q;
  logic [15:0] angle_dir;
  logic [15:0] angle_buf_q;

  assign angle_dir = rotation_ccw ? (16'h0000 - angle_raw) : angle_raw;

  always_ff @(posedge mclk)
  begin
    if (rst)
      refresh_cnt_q <= '0;
    else if (refresh_cnt_q == REFRESH_LAST)
      refresh_cnt_q <= '0;
    else
      refresh_cnt_q <= refresh_cnt_q + RW'(1);
  end

  // A missed tick while frozen waits for the next one; reads repeat meanwhile
  always_ff @(posedge mclk)
  begin
    if (rst)
      angle_buf_q <= '0;
    else if (refresh_cnt_q == REFRESH_LAST && !frozen)
      angle_buf_q <= angle_dir & RES_MASK;
  end

  // Frozen from the synchronised chip select fall; the sync delay stays
  // below the master's lead time so the word is still before the first edge
  always_ff @(posedge mclk)
  begin
    if (rst)
      out_word_q <= '0;
    else if (!frozen)
      out_word_q <= pending_q ? {resp_q, asp_pkg::PAD_BYTE} : angle_buf_q;
  end

  assign rotation_ccw = cfg_q[asp_pkg::REG_ROT_DIR][asp_pkg::ROT_DIR_BIT];
  assign zero_setting = {cfg_q[asp_pkg::REG_ZERO_HI], cfg_q[asp_pkg::REG_ZERO_LO]};
  assign threshold_cfg = cfg_q[asp_pkg::REG_THRESHOLD];
  assign memory_write_wait = wait_cnt_q != '0;

endmodule

/* verilog/asp_spi_if.sv */
interface asp_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic miso;

  // ----------------------------------------------------------------
  // Wire level: pull-down while the sensor end releases the line
  // ----------------------------------------------------------------
  assign miso = miso_oe ? miso_drv : 1'b0;

  modport dev (
    input cs_n,
    input sclk,
    input mosi,
    output miso_drv,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output mosi,
    input miso
  );
endinterface
